/* File: rrt_pkg.sv */
// Package of offsets, field layouts and reset values for the control registers
package rrt_pkg;

  // Register addresses on the control interface
  localparam logic [6:0] RRT_ADDR_REGULATOR = 7'h35;
  localparam logic [6:0] RRT_ADDR_BANDGAP = 7'h36;
  localparam logic [6:0] RRT_ADDR_TOUCH_ONE = 7'h37;

  // Field positions
  localparam int RRT_BIT_ENABLE = 15;
  localparam int RRT_BIT_FAST_REF = 14;
  localparam int RRT_BIT_REF_SEL = 13;
  localparam int RRT_BIT_OUT_FLOAT = 12;
  localparam int RRT_BIT_BIAS_SRC = 5;
  localparam int RRT_BIT_CONV_EN = 14;
  localparam int RRT_CODE_MSB = 4;
  localparam int RRT_CODE_LSB = 0;

  // Field widths and reset values
  localparam int RRT_CODE_W = 5;
  localparam int RRT_DATA_W = 16;
  localparam logic [4:0] RRT_RATIO_RESET = 5'h07;
  localparam logic [4:0] RRT_BANDGAP_RESET = 5'h0a;
  localparam logic [4:0] RRT_RATE_MANUAL = 5'h00;
  localparam logic [4:0] RRT_BANDGAP_CODE_MAX = 5'h0f;
  localparam logic [15:0] RRT_READ_ZERO = 16'h0000;

  // Regulator controls as presented to the analog block
  typedef struct packed {
    logic enable;
    logic fast_ref;
    logic ref_select;
    logic output_float;
    logic bias_source;
    logic [4:0] ratio_code;
  } rrt_regulator_t;

  // Bandgap controls
  typedef struct packed {
    logic enable;
    logic [4:0] voltage_code;
  } rrt_bandgap_t;

  // Touch panel controls
  typedef struct packed {
    logic panel_enable;
    logic conversion_enable;
    logic [4:0] conversion_rate;
  } rrt_touch_t;

endpackage

/* File: rrt_regs.sv */
// Regulator, bandgap and touch panel control register bank
//
// Notes on behaviour
// R01: Regulator bit 13 picks mid-rail (0) or bandgap (1) reference; resets 0.
// R02: Bit 14 picks fast-start mid-rail reference, only when bit 13 is 0.
// R03: Bit 15 enables regulator; bit 12 floats output when disabled, else discharges.
// R04: Bit 5 picks bias source: master (0) or start-up (1); resets 0.
// R05: Bits 4:0 set output ratio of reference; reset value 00111.
// R06: Bandgap enable bit 15 resets 0; code bits 4:0 reset 01010.
// R07: Software programs bandgap codes 00000 to 01111 only; higher reserved.
// R08: Touch register bit 15 panel enable, bit 14 conversion enable; reset 0.
// R09: Automatic rate: conversion enable set runs conversions, clearing stops them.
// R10: Manual rate 0: writing 1 to conversion enable starts one set.
// R11: Manual mode: device clears conversion enable once the set has started.
// R12: Unlisted bits read back zero and ignore writes.
module rrt_regs
  import rrt_pkg::*;
#(
  parameter int DATA_W = RRT_DATA_W
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [6:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_hit,
  input wire logic touch_set_started,
  output rrt_regulator_t regulator_ctrl,
  output rrt_bandgap_t bandgap_ctrl,
  output rrt_touch_t touch_ctrl,
  output logic touch_auto_run,
  output logic touch_single_start
);

  // Elaboration check on the data width
  if (DATA_W != RRT_DATA_W) begin : g_width_check
    $error("rrt_regs supports only 16-bit register data");
  end

  // Stored fields
  logic reg_en_q, reg_fast_q, reg_ref_q, reg_float_q, reg_bias_q;
  logic [4:0] reg_ratio_q;
  logic bg_en_q;
  logic [4:0] bg_code_q;
  logic tch_en_q, tch_cvt_q, tch_cvt_d;
  logic [4:0] touch_conversion_rate_q;
  logic start_q;
  logic [DATA_W-1:0] rdata_q;

  // Address decode
  wire logic hit_reg = reg_addr == RRT_ADDR_REGULATOR;
  wire logic hit_bg = reg_addr == RRT_ADDR_BANDGAP;
  wire logic hit_tch = reg_addr == RRT_ADDR_TOUCH_ONE;
  wire logic wr_reg = reg_write && hit_reg;
  wire logic wr_bg = reg_write && hit_bg;
  wire logic wr_tch = reg_write && hit_tch;
  wire logic [4:0] wr_code = reg_wdata[RRT_CODE_MSB:RRT_CODE_LSB];
  wire logic wr_cvt = reg_wdata[RRT_BIT_CONV_EN];

  // R10: manual start on write of 1
  wire logic manual_kick = wr_tch && wr_cvt && (wr_code == RRT_RATE_MANUAL);
  wire logic manual_mode = touch_conversion_rate_q == RRT_RATE_MANUAL;

  // R11: self clear once started, a new write wins
  always_comb begin
    tch_cvt_d = tch_cvt_q;
    if (manual_mode && touch_set_started) begin
      tch_cvt_d = 1'b0;
    end
    if (wr_tch) begin
      tch_cvt_d = wr_cvt;
    end
  end

  // R01: regulator register write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_en_q <= 1'b0;
      reg_fast_q <= 1'b0;
      reg_ref_q <= 1'b0;
      reg_float_q <= 1'b0;
      reg_bias_q <= 1'b0;
      reg_ratio_q <= RRT_RATIO_RESET;
    end else if (wr_reg) begin
      reg_en_q <= reg_wdata[RRT_BIT_ENABLE];
      reg_fast_q <= reg_wdata[RRT_BIT_FAST_REF];
      reg_ref_q <= reg_wdata[RRT_BIT_REF_SEL];
      reg_float_q <= reg_wdata[RRT_BIT_OUT_FLOAT];
      reg_bias_q <= reg_wdata[RRT_BIT_BIAS_SRC];
      reg_ratio_q <= wr_code;
    end
  end

  // R06: bandgap register write, code stored as written
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bg_en_q <= 1'b0;
      bg_code_q <= RRT_BANDGAP_RESET;
    end else if (wr_bg) begin
      bg_en_q <= reg_wdata[RRT_BIT_ENABLE];
      bg_code_q <= wr_code;
    end
  end

  // R08: touch register write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tch_en_q <= 1'b0;
      touch_conversion_rate_q <= RRT_RATE_MANUAL;
    end else if (wr_tch) begin
      tch_en_q <= reg_wdata[RRT_BIT_ENABLE];
      touch_conversion_rate_q <= wr_code;
    end
  end

  // Conversion enable and one-cycle manual start
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tch_cvt_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      tch_cvt_q <= tch_cvt_d;
      start_q <= manual_kick;
    end
  end

  // R12: read data, unlisted bits zero
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = RRT_READ_ZERO;
    if (hit_reg) begin
      rd_mux[RRT_BIT_ENABLE] = reg_en_q;
      rd_mux[RRT_BIT_FAST_REF] = reg_fast_q;
      rd_mux[RRT_BIT_REF_SEL] = reg_ref_q;
      rd_mux[RRT_BIT_OUT_FLOAT] = reg_float_q;
      rd_mux[RRT_BIT_BIAS_SRC] = reg_bias_q;
      rd_mux[RRT_CODE_MSB:RRT_CODE_LSB] = reg_ratio_q;
    end
    if (hit_bg) begin
      rd_mux[RRT_BIT_ENABLE] = bg_en_q;
      rd_mux[RRT_CODE_MSB:RRT_CODE_LSB] = bg_code_q;
    end
    if (hit_tch) begin
      rd_mux[RRT_BIT_ENABLE] = tch_en_q;
      rd_mux[RRT_BIT_CONV_EN] = tch_cvt_q;
      rd_mux[RRT_CODE_MSB:RRT_CODE_LSB] = touch_conversion_rate_q;
    end
  end

  // Registered read answer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= RRT_READ_ZERO;
    end else if (reg_read) begin
      rdata_q <= rd_mux;
    end
  end

  // Outputs to analog and touch engine
  assign reg_rdata = rdata_q;
  assign reg_hit = hit_reg || hit_bg || hit_tch;
  // R03: enable and float straight from stored bits
  assign regulator_ctrl.enable = reg_en_q;
  // R02: fast start only with mid-rail selected
  assign regulator_ctrl.fast_ref = reg_fast_q && !reg_ref_q;
  assign regulator_ctrl.ref_select = reg_ref_q;
  assign regulator_ctrl.output_float = reg_float_q;
  // R04: bias source
  assign regulator_ctrl.bias_source = reg_bias_q;
  // R05: ratio code
  assign regulator_ctrl.ratio_code = reg_ratio_q;
  assign bandgap_ctrl.enable = bg_en_q;
  assign bandgap_ctrl.voltage_code = bg_code_q;
  assign touch_ctrl.panel_enable = tch_en_q;
  assign touch_ctrl.conversion_enable = tch_cvt_q;
  assign touch_ctrl.conversion_rate = touch_conversion_rate_q;
  // R09: automatic conversions run while enabled
  assign touch_auto_run = tch_cvt_q && !manual_mode;
  assign touch_single_start = start_q;

  // Checks, all on the core clock; reset held over two edges
  sequence s_in_reset;
    !resetn ##1 !resetn;
  endsequence

  // R02: fast start masked
  AST_FAST_MASKED: assert property ( // R02
    @(posedge core_clk) disable iff (!resetn)
    reg_ref_q |-> !regulator_ctrl.fast_ref)
    else $error("fast reference active with bandgap selected");

  // R01: reference select written
  AST_REF_SEL_WRITE: assert property ( // R01
    @(posedge core_clk) disable iff (!resetn)
    wr_reg |=> regulator_ctrl.ref_select == $past(reg_wdata[RRT_BIT_REF_SEL]))
    else $error("reference select not taken from write");

  // R03: enable and float written
  AST_ENABLE_FLOAT: assert property ( // R03
    @(posedge core_clk) disable iff (!resetn)
    wr_reg |=> regulator_ctrl.enable == $past(reg_wdata[RRT_BIT_ENABLE])
      && regulator_ctrl.output_float == $past(reg_wdata[RRT_BIT_OUT_FLOAT]))
    else $error("enable or float not taken from write");

  // R03: regulator bits cleared in reset
  AST_ENABLE_RESET: assert property ( // R03
    @(posedge core_clk)
    s_in_reset |-> !regulator_ctrl.enable && !regulator_ctrl.output_float
      && !regulator_ctrl.ref_select && !regulator_ctrl.bias_source)
    else $error("regulator bits not cleared in reset");

  // R04: bias source held
  AST_BIAS_HOLD: assert property ( // R04
    @(posedge core_clk) disable iff (!resetn)
    !wr_reg |=> $stable(regulator_ctrl.bias_source))
    else $error("bias source changed without write");

  // R05: ratio code written
  AST_RATIO_WRITE: assert property ( // R05
    @(posedge core_clk) disable iff (!resetn)
    wr_reg |=> regulator_ctrl.ratio_code == $past(wr_code))
    else $error("ratio code not taken from write");

  // R05: ratio code reset value
  AST_RATIO_RESET: assert property ( // R05
    @(posedge core_clk)
    s_in_reset |-> regulator_ctrl.ratio_code == RRT_RATIO_RESET)
    else $error("ratio code not at reset value");

  // R06: bandgap fields written
  AST_BANDGAP_WRITE: assert property ( // R06
    @(posedge core_clk) disable iff (!resetn)
    wr_bg |=> bandgap_ctrl.voltage_code == $past(wr_code)
      && bandgap_ctrl.enable == $past(reg_wdata[RRT_BIT_ENABLE]))
    else $error("bandgap fields not taken from write");

  // R06: bandgap reset values
  AST_BANDGAP_RESET: assert property ( // R06
    @(posedge core_clk)
    s_in_reset |-> !bandgap_ctrl.enable
      && bandgap_ctrl.voltage_code == RRT_BANDGAP_RESET)
    else $error("bandgap fields not at reset value");

  // R08: touch enables written
  AST_TOUCH_WRITE: assert property ( // R08
    @(posedge core_clk) disable iff (!resetn)
    wr_tch |=> touch_ctrl.panel_enable == $past(reg_wdata[RRT_BIT_ENABLE])
      && touch_ctrl.conversion_enable == $past(wr_cvt))
    else $error("touch enables not taken from write");

  // R08: touch fields cleared in reset
  AST_TOUCH_RESET: assert property ( // R08
    @(posedge core_clk)
    s_in_reset |-> !touch_ctrl.panel_enable
      && !touch_ctrl.conversion_enable
      && touch_ctrl.conversion_rate == RRT_RATE_MANUAL)
    else $error("touch fields not cleared in reset");

  // R09: automatic run starts
  AST_AUTO_RUN: assert property ( // R09
    @(posedge core_clk) disable iff (!resetn)
    wr_tch && wr_cvt && wr_code != RRT_RATE_MANUAL
      |=> touch_auto_run)
    else $error("automatic run not started by write");

  // R09: clearing stops runs
  AST_AUTO_STOP: assert property ( // R09
    @(posedge core_clk) disable iff (!resetn)
    wr_tch && !wr_cvt |=> !touch_auto_run)
    else $error("automatic run not stopped by write");

  // R09: automatic enable kept
  AST_AUTO_KEEP: assert property ( // R09
    @(posedge core_clk) disable iff (!resetn)
    !manual_mode && touch_set_started && !wr_tch
      |=> $stable(touch_ctrl.conversion_enable))
    else $error("automatic enable cleared by a started set");

  // Manual start: the write, then a pulse of one cycle
  sequence s_manual_write;
    manual_kick;
  endsequence
  sequence s_start_pulse;
    touch_single_start ##1 (touch_single_start == $past(manual_kick));
  endsequence

  // R10: start pulse follows
  AST_MANUAL_START: assert property ( // R10
    @(posedge core_clk) disable iff (!resetn)
    s_manual_write |=> s_start_pulse)
    else $error("manual start pulse missing");

  // R10: no stray pulse
  AST_NO_STRAY_START: assert property ( // R10
    @(posedge core_clk) disable iff (!resetn)
    !manual_kick |=> !touch_single_start)
    else $error("start pulse without manual write");

  sequence s_set_started;
    manual_mode && touch_set_started && !wr_tch;
  endsequence

  // R11: self clear
  AST_SELF_CLEAR: assert property ( // R11
    @(posedge core_clk) disable iff (!resetn)
    s_set_started |=> !touch_ctrl.conversion_enable)
    else $error("conversion enable not cleared after start");

  // R11: cleared bit reads back
  AST_CLEAR_READBACK: assert property ( // R11
    @(posedge core_clk) disable iff (!resetn)
    s_set_started ##1 (reg_read && hit_tch)
      |=> !reg_rdata[RRT_BIT_CONV_EN])
    else $error("cleared conversion enable reads back set");

  // R12: unmapped reads zero
  AST_READ_ZERO: assert property ( // R12
    @(posedge core_clk) disable iff (!resetn)
    reg_read && !reg_hit |=> reg_rdata == RRT_READ_ZERO)
    else $error("unmapped read not zero");

  // R12: spare bandgap bits zero
  AST_BG_SPARE_ZERO: assert property ( // R12
    @(posedge core_clk) disable iff (!resetn)
    reg_read && hit_bg
      |=> reg_rdata[RRT_BIT_ENABLE-1:RRT_CODE_MSB+1] == '0)
    else $error("spare bandgap bits not zero");

endmodule

/* File: rrt_tb.sv */
// Self-checking bench for the control register bank
module tb
  import rrt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic touch_set_started = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic reg_hit;
  logic touch_auto_run;
  logic touch_single_start;
  rrt_regulator_t regulator_ctrl;
  rrt_bandgap_t bandgap_ctrl;
  rrt_touch_t touch_ctrl;
  logic [15:0] m_reg, m_bg, m_tch;
  logic [31:0] seed = 32'h0001_1c07;
  logic [6:0] ra;
  logic [15:0] wd;
  int err_total = 0;
  int samples_checked = 0;

  // Expected control words, worked out from the register model
  function automatic logic [15:0] exp_reg();
    return {6'h00, m_reg[15], m_reg[14] & ~m_reg[13], m_reg[13:12],
            m_reg[5:0]};
  endfunction

  function automatic logic [15:0] exp_bg();
    return {10'h000, m_bg[15], m_bg[4:0]};
  endfunction

  function automatic logic [15:0] exp_tch();
    return {9'h000, m_tch[15:14], m_tch[4:0]};
  endfunction

  function automatic logic exp_auto();
    return m_tch[14] & (m_tch[4:0] != RRT_RATE_MANUAL);
  endfunction

  rrt_regs i_dut (
    .core_clk(core_clk), .resetn(resetn), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .touch_set_started(touch_set_started), .regulator_ctrl(regulator_ctrl),
    .bandgap_ctrl(bandgap_ctrl), .touch_ctrl(touch_ctrl),
    .touch_auto_run(touch_auto_run), .touch_single_start(touch_single_start)
  );

  // Free-running core clock
  always #5 core_clk = ~core_clk;

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Writable bits of each register, zero when unmapped
  function automatic logic [15:0] mask(logic [6:0] a);
    case (a)
      RRT_ADDR_REGULATOR: return 16'hf03f;
      RRT_ADDR_BANDGAP: return 16'h801f;
      RRT_ADDR_TOUCH_ONE: return 16'hc01f;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] model(logic [6:0] a);
    case (a)
      RRT_ADDR_REGULATOR: return m_reg;
      RRT_ADDR_BANDGAP: return m_bg;
      RRT_ADDR_TOUCH_ONE: return m_tch;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk_outs();
    chk("regulator", 16'(regulator_ctrl), exp_reg());
    chk("bandgap", 16'(bandgap_ctrl), exp_bg());
    chk("touch", 16'(touch_ctrl), exp_tch());
    chk("auto_run", {15'h0000, touch_auto_run}, {15'h0000, exp_auto()});
  endtask

  task automatic wr(logic [6:0] a, logic [15:0] d);
    logic st;
    st = (a == RRT_ADDR_TOUCH_ONE) && d[14] && (d[4:0] == RRT_RATE_MANUAL);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    #1 chk("hit", {15'h0000, reg_hit}, {15'h0000, mask(a) != 16'h0000});
    @(negedge core_clk);
    reg_write = 1'b0;
    if (a == RRT_ADDR_REGULATOR) m_reg = d & mask(a);
    if (a == RRT_ADDR_BANDGAP) m_bg = d & mask(a);
    if (a == RRT_ADDR_TOUCH_ONE) m_tch = d & mask(a);
    chk("start", {15'h0000, touch_single_start}, {15'h0000, st});
    chk_outs();
    @(negedge core_clk);
    chk("start_end", {15'h0000, touch_single_start}, 16'h0000);
  endtask

  task automatic rd(logic [6:0] a);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_read = 1'b0;
    chk("rdata", reg_rdata, model(a));
    @(negedge core_clk);
  endtask

  task automatic started();
    touch_set_started = 1'b1;
    @(negedge core_clk);
    touch_set_started = 1'b0;
    if (m_tch[4:0] == RRT_RATE_MANUAL) m_tch[14] = 1'b0;
    chk_outs();
  endtask

  task automatic do_reset();
    resetn = 1'b0;
    m_reg = {11'h000, RRT_RATIO_RESET};
    m_bg = {11'h000, RRT_BANDGAP_RESET};
    m_tch = 16'h0000;
    repeat (5) @(negedge core_clk);
    chk_outs();
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) rd(7'h35 + 7'(i));
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence: corners first, then random traffic
  initial begin
    do_reset();
    wr(RRT_ADDR_TOUCH_ONE, 16'hc000);
    rd(RRT_ADDR_TOUCH_ONE);
    started();
    rd(RRT_ADDR_TOUCH_ONE);
    wr(RRT_ADDR_TOUCH_ONE, 16'h4003);
    started();
    wr(RRT_ADDR_TOUCH_ONE, 16'h0003);
    wr(RRT_ADDR_REGULATOR, 16'h6000);
    wr(RRT_ADDR_REGULATOR, 16'h4000);
    wr(RRT_ADDR_BANDGAP, 16'hffef);
    wr(RRT_ADDR_REGULATOR, 16'hffff);
    rd(RRT_ADDR_REGULATOR);
    for (int n = 0; n < 80; n++) begin
      seed = xs(seed);
      ra = (seed[1:0] == 2'd3) ? seed[8:2] : 7'h35 + 7'(seed[1:0]);
      wd = seed[31:16];
      // Reserved bandgap codes are never written
      if (ra == RRT_ADDR_BANDGAP) wd[4] = 1'b0;
      wr(ra, wd);
      rd(ra);
      if (seed[10]) started();
      if (n == 40) do_reset();
    end
    stop_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #20000;
    err_total++;
    stop_test();
  end
endmodule
